// *** common/flash_rw_cfg.svh ***
`ifndef FLASH_RW_CFG_SVH
`define FLASH_RW_CFG_SVH

// ****************************************
// Register offsets
// ****************************************
`define REG_CTRL             8'h00
`define REG_SUSPEND          8'h04
`define REG_CMD              8'h08
`define REG_MODE             8'h0C

// ****************************************
// Field positions
// ****************************************
`define CTRL_READY_BIT       0
`define CTRL_REWRITE_EN_BIT  1
`define CTRL_BLK0_EN_BIT     2
`define CTRL_SECOND_SEL_BIT  3
`define CTRL_ABORT_FLAG_BIT  7
`define SUS_ERS_EN_BIT       0
`define SUS_ERS_REQ_BIT      1
`define SUS_PRG_EN_BIT       2
`define SUS_PRG_REQ_BIT      3
`define SUS_SUSPENDED_BIT    6
`define CMD_PROGRAM_BIT      0
`define CMD_ERASE_BIT        1
`define CMD_BLOCK0_BIT       2
`define MODE_SERIAL_BIT      0
`define MODE_VARIANT3_BIT    1
`define MODE_ID_OK_BIT       2
`define MODE_PAR_EN_BIT      3

// ****************************************
// Timing
// ****************************************
`define CLK_PERIOD_NS        10
`define PROG_TIME_US         50
`define ERASE_TIME_US        400000
`define SUSPEND_DELAY_US     97
`define SUSPEND_EXTRA_CLK    6
`define RESTART_DELAY_US     3
`define RESTART_EXTRA_CLK    4
`define RESTART_DELAY_CYC    ((`RESTART_DELAY_US * 1000) / `CLK_PERIOD_NS + `RESTART_EXTRA_CLK)
`define ABORT_DELAY_CYC      16

// ****************************************
// Identification
// ****************************************
`define ID_CODE_BYTES        7

`endif

// *** common/flash_rw_pkg.sv ***
package flash_rw_pkg;

  typedef enum logic [2:0] {
    IDLE_S        = 3'h0,
    BUSY_S        = 3'h1,
    SUSP_WAIT_S   = 3'h2,
    SUSPENDED_S   = 3'h3,
    RESUME_WAIT_S = 3'h4,
    ABORT_WAIT_S  = 3'h5
  } seq_state_e;

endpackage

// *** rtl/id_code_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "flash_rw_cfg.svh"

module id_code_checker (
  input  wire logic                          clock_in,
  input  wire logic                          rstn_in,
  input  wire logic                          byte_valid_in,
  input  wire logic [7:0]                    byte_in,
  input  wire logic [8*`ID_CODE_BYTES-1:0]   stored_codes_in,
  output var  logic                          match_out
);

  typedef struct packed {
    logic [3:0] idx;
    logic       mismatch;
    logic       match;
  } chk_s;

  chk_s q;
  chk_s d;

  // ****************************************
  // Byte-by-byte compare against stored codes
  // ****************************************
  always_comb begin
    d = q;
    if (byte_valid_in && q.idx < 4'(`ID_CODE_BYTES)) begin
      d.idx = q.idx + 4'h1;
      if (byte_in != stored_codes_in[8*q.idx +: 8]) begin
        d.mismatch = 1'b1;
      end
      if (q.idx == 4'(`ID_CODE_BYTES - 1)) begin
        d.match = ~d.mismatch;
      end
    end
  end

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign match_out = q.match;

endmodule
`default_nettype wire

// *** rtl/flash_rewrite_interrupt_suspend_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "flash_rw_cfg.svh"

module flash_rewrite_interrupt_suspend_ctrl #(
  parameter logic [31:0] PROG_CYC    = `PROG_TIME_US * 1000 / `CLK_PERIOD_NS,
  parameter logic [31:0] ERASE_CYC   = `ERASE_TIME_US * 1000 / `CLK_PERIOD_NS,
  parameter logic [31:0] SUSPEND_CYC = `SUSPEND_DELAY_US * 1000 / `CLK_PERIOD_NS
                                       + `SUSPEND_EXTRA_CLK
) (
  input  wire logic                         clock_in,
  input  wire logic                         rstn_in,
  input  wire logic [7:0]                   addr_in,
  input  wire logic [7:0]                   wdata_in,
  input  wire logic                         wr_in,
  input  wire logic                         rd_in,
  output var  logic [7:0]                   rdata_out,
  input  wire logic                         maskable_irq_req_in,
  input  wire logic                         vector_in_ram_in,
  input  wire logic                         abort_req_in,
  output var  logic                         irq_grant_out,
  output var  logic                         abort_grant_out,
  output var  logic                         flash_reset_out,
  output var  logic                         ready_out,
  input  wire logic                         mode_pin_in,
  output var  logic                         mode_pin_out,
  output var  logic                         mode_pin_oe_out,
  input  wire logic                         variant3_sel_in,
  input  wire logic                         rxd_in,
  output var  logic                         txd_out,
  input  wire logic                         serial_tx_bit_in,
  input  wire logic                         serial_tx_en_in,
  output var  logic                         serial_rx_bit_out,
  input  wire logic                         id_byte_valid_in,
  input  wire logic [7:0]                   id_byte_in,
  input  wire logic [8*`ID_CODE_BYTES-1:0]  id_stored_in,
  output var  logic                         serial_access_out,
  input  wire logic                         parallel_mode_in,
  input  wire logic                         rom_code_protect_in,
  output var  logic                         parallel_rd_out,
  output var  logic                         parallel_wr_out
);

  typedef struct packed {
    flash_rw_pkg::seq_state_e state;
    logic [31:0] cnt;
    logic [31:0] remain;
    logic        op_erase;
    logic        op_blk0;
    logic        ready;
    logic [2:0]  guard;
    logic [2:0]  arm;
    logic        abort_flag;
    logic        ers_sus_en;
    logic        ers_sus_req;
    logic        prg_sus_en;
    logic        prg_sus_req;
    logic        irq_grant;
    logic        abort_grant;
    logic        flash_reset;
    logic [7:0]  rdata;
    logic        strap_done;
    logic        serial_mode;
    logic        txd;
    logic        mode_o;
    logic        mode_oe;
    logic        rx_bit;
    logic        serial_access;
    logic        par_rd;
    logic        par_wr;
  } ctrl_s;

  ctrl_s q;
  ctrl_s d;

  logic       id_match;
  logic       wr_ctrl;
  logic       mode1;
  logic       mode2;
  logic       op_active;
  logic       kind_sus_en;
  logic       kind_sus_req;
  logic [2:0] guard_nxt;
  logic [2:0] arm_nxt;

  id_code_checker u_id_check (
    .clock_in        (clock_in),
    .rstn_in         (rstn_in),
    .byte_valid_in   (id_byte_valid_in & q.serial_mode),
    .byte_in         (id_byte_in),
    .stored_codes_in (id_stored_in),
    .match_out       (id_match)
  );

  assign wr_ctrl      = wr_in && (addr_in == `REG_CTRL);
  assign mode1        = q.guard[0] & ~q.guard[2];
  assign mode2        = q.guard[0] & q.guard[2];
  assign op_active    = (q.state != flash_rw_pkg::IDLE_S) && (q.state != flash_rw_pkg::ABORT_WAIT_S);
  assign kind_sus_en  = q.op_erase ? q.ers_sus_en : q.prg_sus_en;
  assign kind_sus_req = q.op_erase ? q.ers_sus_req : q.prg_sus_req;

  // ****************************************
  // Guarded enable bits
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_guard
      always_comb begin
        guard_nxt[g] = q.guard[g];
        arm_nxt[g]   = q.arm[g];
        if (wr_ctrl) begin
          // One only after a 0 write just before, or if already one
          guard_nxt[g] = wdata_in[`CTRL_REWRITE_EN_BIT + g] & (q.arm[g] | q.guard[g]);
          arm_nxt[g]   = ~wdata_in[`CTRL_REWRITE_EN_BIT + g];
        end else if (wr_in) begin
          arm_nxt[g] = 1'b0;
        end
        if (q.irq_grant || q.abort_grant) begin
          arm_nxt[g] = 1'b0;
        end
      end
    end
  endgenerate

  // ****************************************
  // Sequencer, suspend and interrupt gating
  // ****************************************
  always_comb begin
    d             = q;
    d.guard       = guard_nxt;
    d.arm         = arm_nxt;
    d.abort_grant = 1'b0;
    d.flash_reset = 1'b0;
    d.rdata       = 8'h00;
    if (wr_in && addr_in == `REG_CTRL && wdata_in[`CTRL_ABORT_FLAG_BIT]) begin
      d.abort_flag = 1'b0;
    end
    if (wr_in && addr_in == `REG_SUSPEND) begin
      d.ers_sus_en  = wdata_in[`SUS_ERS_EN_BIT];
      d.ers_sus_req = wdata_in[`SUS_ERS_REQ_BIT];
      d.prg_sus_en  = wdata_in[`SUS_PRG_EN_BIT];
      d.prg_sus_req = wdata_in[`SUS_PRG_REQ_BIT];
    end
    // Interrupt during operation in second mode raises the suspend request
    if (maskable_irq_req_in && q.state == flash_rw_pkg::BUSY_S && mode2) begin
      if (q.op_erase && q.ers_sus_en) begin
        d.ers_sus_req = 1'b1;
      end
      if (!q.op_erase && q.prg_sus_en) begin
        d.prg_sus_req = 1'b1;
      end
    end
    d.cnt = (q.cnt != 32'h0) ? q.cnt - 32'h1 : 32'h0;
    unique case (q.state)
      flash_rw_pkg::IDLE_S: begin
        if (wr_in && addr_in == `REG_CMD && q.guard[0] &&
            (wdata_in[`CMD_PROGRAM_BIT] || wdata_in[`CMD_ERASE_BIT]) &&
            (!wdata_in[`CMD_BLOCK0_BIT] || q.guard[1])) begin
          d.state    = flash_rw_pkg::BUSY_S;
          d.op_erase = wdata_in[`CMD_ERASE_BIT];
          d.op_blk0  = wdata_in[`CMD_BLOCK0_BIT];
          d.remain   = wdata_in[`CMD_ERASE_BIT] ? ERASE_CYC - 32'h1 : PROG_CYC - 32'h1;
          d.ready    = 1'b0;
        end
      end
      flash_rw_pkg::BUSY_S: begin
        d.remain = q.remain - 32'h1;
        if (q.remain == 32'h0) begin
          d.state = flash_rw_pkg::IDLE_S;
          d.ready = 1'b1;
        end else if (mode2 && kind_sus_en && (q.op_erase ? d.ers_sus_req : d.prg_sus_req)) begin
          d.remain = q.remain;
          d.state  = flash_rw_pkg::SUSP_WAIT_S;
          d.cnt    = SUSPEND_CYC - 32'h1;
        end
      end
      flash_rw_pkg::SUSP_WAIT_S: begin
        if (q.cnt == 32'h0) begin
          d.state = flash_rw_pkg::SUSPENDED_S;
        end
      end
      flash_rw_pkg::SUSPENDED_S: begin
        // Context held until software clears the request
        if (!kind_sus_req) begin
          d.state = flash_rw_pkg::RESUME_WAIT_S;
          d.cnt   = 32'(`RESTART_DELAY_CYC) - 32'h1;
        end
      end
      flash_rw_pkg::RESUME_WAIT_S: begin
        if (q.cnt == 32'h0) begin
          d.state = flash_rw_pkg::BUSY_S;
        end
      end
      flash_rw_pkg::ABORT_WAIT_S: begin
        if (q.cnt == 32'h0) begin
          d.state       = flash_rw_pkg::IDLE_S;
          d.abort_grant = 1'b1;
        end
      end
    endcase
    if (abort_req_in) begin
      if (op_active) begin
        d.state       = flash_rw_pkg::ABORT_WAIT_S;
        d.flash_reset = 1'b1;
        d.abort_flag  = 1'b1;
        d.ready       = 1'b1;
        d.ers_sus_req = 1'b0;
        d.prg_sus_req = 1'b0;
        d.cnt         = 32'(`ABORT_DELAY_CYC) - 32'h1;
      end else if (q.state == flash_rw_pkg::IDLE_S) begin
        d.abort_grant = 1'b1;
      end
    end
    // Maskable interrupts: free when idle or suspended, RAM vector in first mode
    d.irq_grant = maskable_irq_req_in &&
                  (q.state == flash_rw_pkg::IDLE_S ||
                   q.state == flash_rw_pkg::SUSPENDED_S ||
                   (op_active && mode1 && vector_in_ram_in));
    // Programmer link
    if (!q.strap_done) begin
      d.strap_done  = 1'b1;
      d.serial_mode = ~mode_pin_in;
    end
    d.txd     = 1'b1;
    d.mode_o  = 1'b0;
    d.mode_oe = 1'b0;
    d.rx_bit  = 1'b1;
    if (q.serial_mode && variant3_sel_in) begin
      d.mode_o  = serial_tx_bit_in;
      d.mode_oe = serial_tx_en_in;
      d.rx_bit  = mode_pin_in;
    end else if (q.serial_mode) begin
      d.txd    = serial_tx_bit_in;
      d.rx_bit = rxd_in;
    end
    d.serial_access = q.serial_mode & id_match;
    d.par_rd        = parallel_mode_in & ~rom_code_protect_in;
    d.par_wr        = parallel_mode_in & ~rom_code_protect_in;
    if (rd_in) begin
      unique case (addr_in)
        `REG_CTRL:    d.rdata = {q.abort_flag, 3'h0, q.guard, q.ready};
        `REG_SUSPEND: d.rdata = {1'b0, q.state == flash_rw_pkg::SUSPENDED_S, 2'h0,
                                 q.prg_sus_req, q.prg_sus_en, q.ers_sus_req, q.ers_sus_en};
        `REG_CMD:     d.rdata = {5'h00, q.op_blk0, q.op_erase, ~q.op_erase};
        `REG_MODE:    d.rdata = {4'h0, q.par_rd, id_match, variant3_sel_in, q.serial_mode};
        default:      d.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      q       <= '0;
      q.ready <= 1'b1;
      q.txd   <= 1'b1;
      q.rx_bit <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign rdata_out         = q.rdata;
  assign irq_grant_out     = q.irq_grant;
  assign abort_grant_out   = q.abort_grant;
  assign flash_reset_out   = q.flash_reset;
  assign ready_out         = q.ready;
  assign mode_pin_out      = q.mode_o;
  assign mode_pin_oe_out   = q.mode_oe;
  assign txd_out           = q.txd;
  assign serial_rx_bit_out = q.rx_bit;
  assign serial_access_out = q.serial_access;
  assign parallel_rd_out   = q.par_rd;
  assign parallel_wr_out   = q.par_wr;

  // ****************************************
  // Assertions
  // ****************************************
  localparam int ABORT_DLY = `ABORT_DELAY_CYC;

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rstn_in);

  property p_ready_busy;
    (q.state != flash_rw_pkg::IDLE_S && q.state != flash_rw_pkg::ABORT_WAIT_S) |-> !ready_out;
  endproperty
  a_ready_busy: assert property (p_ready_busy) else $error("ready high during operation");

  property p_abort_now;
    (abort_req_in && op_active) |=> flash_reset_out && q.state == flash_rw_pkg::ABORT_WAIT_S;
  endproperty
  a_abort_now: assert property (p_abort_now) else $error("abort not immediate");

  property p_abort_delay;
    flash_reset_out && !abort_req_in |-> ##ABORT_DLY abort_grant_out;
  endproperty
  a_abort_delay: assert property (p_abort_delay) else $error("abort grant delay wrong");

  property p_abort_quiet;
    q.state == flash_rw_pkg::ABORT_WAIT_S |-> !abort_grant_out;
  endproperty
  a_abort_quiet: assert property (p_abort_quiet) else $error("abort grant too early");

  property p_hold_irq;
    (q.state == flash_rw_pkg::BUSY_S && !mode1) |=> !irq_grant_out;
  endproperty
  a_hold_irq: assert property (p_hold_irq) else $error("interrupt not held");

  property p_ram_vector;
    (op_active && mode1 && vector_in_ram_in && maskable_irq_req_in) |=> irq_grant_out;
  endproperty
  a_ram_vector: assert property (p_ram_vector) else $error("RAM vector irq not served");

  property p_suspend_end;
    (q.state == flash_rw_pkg::SUSP_WAIT_S && q.cnt == 32'h0 && !abort_req_in)
      |=> q.state == flash_rw_pkg::SUSPENDED_S ##1 (irq_grant_out || !$past(maskable_irq_req_in));
  endproperty
  a_suspend_end: assert property (p_suspend_end) else $error("suspend not reached");

  property p_hold_suspend;
    (q.state == flash_rw_pkg::SUSPENDED_S && kind_sus_req && !abort_req_in)
      |=> q.state == flash_rw_pkg::SUSPENDED_S && $stable(q.remain);
  endproperty
  a_hold_suspend: assert property (p_hold_suspend) else $error("suspend context lost");

  property p_resume;
    (q.state == flash_rw_pkg::SUSPENDED_S && !kind_sus_req && !abort_req_in)
      |=> q.state == flash_rw_pkg::RESUME_WAIT_S;
  endproperty
  a_resume: assert property (p_resume) else $error("no resume after clear");

  property p_guard;
    (wr_ctrl && wdata_in[`CTRL_REWRITE_EN_BIT] && !q.arm[0] && !q.guard[0]) |=> !q.guard[0];
  endproperty
  a_guard: assert property (p_guard) else $error("guarded bit set without 0 write");

  property p_id;
    !id_match |=> !serial_access_out;
  endproperty
  a_id: assert property (p_id) else $error("serial access without ID match");

  property p_protect;
    rom_code_protect_in |=> !parallel_rd_out && !parallel_wr_out;
  endproperty
  a_protect: assert property (p_protect) else $error("protected flash accessible");

  property p_variant2;
    (q.serial_mode && !variant3_sel_in) |=> !mode_pin_oe_out;
  endproperty
  a_variant2: assert property (p_variant2) else $error("mode pin driven in variant 2");

  c_abort:   cover property (abort_req_in && op_active);
  c_suspend: cover property (q.state == flash_rw_pkg::SUSPENDED_S);
  c_resume:  cover property (q.state == flash_rw_pkg::RESUME_WAIT_S ##1 1'b1);
  c_id_ok:   cover property (serial_access_out);

endmodule
`default_nettype wire

// *** bench/flash_programmer_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module flash_programmer_model (
  input  wire logic clock_in,
  input  wire logic hold_low_in,
  input  wire logic drive_en_in,
  input  wire logic drive_bit_in,
  input  wire logic dev_oe_in,
  input  wire logic dev_bit_in,
  output var  logic pin_out
);
  // ********
  // Mode pin wire
  // ********
  logic own_en_r = 1'b1;
  logic own_bit_r = 1'b0;

  always @(posedge clock_in) begin
    own_en_r <= hold_low_in | drive_en_in;
    own_bit_r <= drive_en_in & drive_bit_in;
  end

  // Released line floats to the pull-up level
  assign pin_out = dev_oe_in ? dev_bit_in : (own_en_r ? own_bit_r : 1'b1);
endmodule

`default_nettype wire

// *** bench/flash_rewrite_interrupt_suspend_ctrl_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "flash_rw_cfg.svh"
module flash_rewrite_interrupt_suspend_ctrl_bench;
  // ********
  // Signals
  // ********
  localparam int PROG = 32'h14;
  localparam int ERASE = 32'h28;
  localparam int SUSP = 32'h8;
  localparam int RESUME = 32'h130;
  logic       clk = 1'b0, rstn_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0, abort_req_in = 1'b0;
  logic       maskable_irq_req_in = 1'b0, vector_in_ram_in = 1'b0, variant3_sel_in = 1'b0;
  logic       rxd_in = 1'b1, serial_tx_bit_in = 1'b1, serial_tx_en_in = 1'b0;
  logic       id_byte_valid_in = 1'b0, parallel_mode_in = 1'b0, rom_code_protect_in = 1'b0;
  logic       hold = 1'b1, pg_en = 1'b0, pg_bit = 1'b1, mode_pin_in;
  logic [7:0] addr_in = 8'h00, wdata_in = 8'h00, id_byte_in = 8'h00, rdata_out;
  logic       irq_grant_out, abort_grant_out, flash_reset_out, ready_out, mode_pin_out;
  logic       mode_pin_oe_out, txd_out, serial_rx_bit_out, serial_access_out;
  logic       parallel_rd_out, parallel_wr_out;
  logic [8*`ID_CODE_BYTES-1:0] id_stored_in = 56'h1D2C3B4A596877;
  int         failures = 0, total_checks = 0;
  flash_programmer_model model (.clock_in(clk), .hold_low_in(hold), .drive_en_in(pg_en),
    .drive_bit_in(pg_bit), .dev_oe_in(mode_pin_oe_out), .dev_bit_in(mode_pin_out),
    .pin_out(mode_pin_in));
  flash_rewrite_interrupt_suspend_ctrl #(
    .PROG_CYC(PROG), .ERASE_CYC(ERASE), .SUSPEND_CYC(SUSP)
  ) uut (
    .clock_in(clk), .rstn_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
    .maskable_irq_req_in, .vector_in_ram_in, .abort_req_in, .irq_grant_out,
    .abort_grant_out, .flash_reset_out, .ready_out, .mode_pin_in, .mode_pin_out,
    .mode_pin_oe_out, .variant3_sel_in, .rxd_in, .txd_out, .serial_tx_bit_in,
    .serial_tx_en_in, .serial_rx_bit_out, .id_byte_valid_in, .id_byte_in,
    .id_stored_in, .serial_access_out, .parallel_mode_in, .rom_code_protect_in,
    .parallel_rd_out, .parallel_wr_out
  );
  initial begin
    forever #5 clk = ~clk;
  end
  // ********
  // Tasks and scenarios
  // ********
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_in(input int n, input int lo, input int hi);
    total_checks++;
    if (n < lo || n > hi) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h..%h", $time, n, lo, hi);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk);
    wr_in <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge clk);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk);
    rd_in <= 1'b0;
    #1;
    chk(rdata_out & m, e);
  endtask
  task automatic rst(input logic strap_low);
    @(posedge clk);
    hold <= strap_low;
    rstn_in <= 1'b0;
    repeat (4) @(posedge clk);
    rstn_in <= 1'b1;
    tick(2);
  endtask
  task automatic results;
    if (failures == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic t_reset_vals;
    chk({5'h00, ready_out, txd_out, serial_rx_bit_out}, 8'h07);
    rd_chk(8'h00, 8'hFF, 8'h01);
    rd_chk(8'h04, 8'hFF, 8'h00);
    rd_chk(8'h10, 8'hFF, 8'h00);
  endtask
  task automatic t_guard;
    wr(8'h00, 8'h02);
    rd_chk(8'h00, 8'h0E, 8'h00);
    wr(8'h00, 8'h00);
    wr(8'h04, 8'h00);
    wr(8'h00, 8'h02);
    rd_chk(8'h00, 8'h0E, 8'h00);
    wr(8'h00, 8'h00);
    wr(8'h00, 8'h0E);
    rd_chk(8'h00, 8'h0E, 8'h0E);
  endtask
  task automatic t_abort;
    int n;
    n = 0;
    wr(8'h00, 8'h00);
    wr(8'h00, 8'h02);
    wr(8'h08, 8'h05);
    rd_chk(8'h00, 8'h01, 8'h01);
    wr(8'h08, 8'h01);
    maskable_irq_req_in <= 1'b1;
    vector_in_ram_in <= 1'b1;
    tick(3);
    chk({6'h00, ready_out, irq_grant_out}, 8'h01);
    @(posedge clk);
    vector_in_ram_in <= 1'b0;
    tick(3);
    chk({6'h00, ready_out, irq_grant_out}, 8'h00);
    @(posedge clk);
    maskable_irq_req_in <= 1'b0;
    abort_req_in <= 1'b1;
    @(posedge clk);
    abort_req_in <= 1'b0;
    #1;
    chk({5'h00, flash_reset_out, ready_out, abort_grant_out}, 8'h06);
    while (abort_grant_out !== 1'b1 && n < 99) begin
      tick(1);
      n++;
    end
    chk_in(n, 16, 16);
    tick(1);
    chk({7'h00, abort_grant_out}, 8'h00);
    rd_chk(8'h00, 8'h80, 8'h80);
    wr(8'h00, 8'h80);
    rd_chk(8'h00, 8'h80, 8'h00);
  endtask
  task automatic suspend_run(input logic [7:0] cmd, input logic en);
    int n;
    int len;
    logic [7:0] sv;
    logic [7:0] req;
    logic held;
    n = 0;
    len = cmd[1] ? ERASE : PROG;
    sv = en ? (cmd[1] ? 8'h01 : 8'h04) : 8'h00;
    req = cmd[1] ? 8'h02 : 8'h08;
    held = 1'b1;
    wr(8'h00, 8'h00);
    wr(8'h00, 8'h0A);
    wr(8'h04, sv);
    wr(8'h08, cmd);
    maskable_irq_req_in <= 1'b1;
    tick(1);
    while ((en ? irq_grant_out : ready_out) !== 1'b1 && n < 999) begin
      if (irq_grant_out !== 1'b0) held = 1'b0;
      tick(1);
      n++;
    end
    if (en) begin
      chk_in(n, SUSP - 1, SUSP + 5);
      tick(40);
      chk({6'h00, ready_out, irq_grant_out}, 8'h01);
      rd_chk(8'h04, 8'h4F, sv | req | 8'h40);
      @(posedge clk);
      maskable_irq_req_in <= 1'b0;
      wr(8'h04, sv);
      n = 0;
      while (ready_out !== 1'b1 && n < 999) begin
        tick(1);
        n++;
      end
      chk_in(n, RESUME - 1, RESUME + len + 4);
      rd_chk(8'h04, 8'h40, 8'h00);
    end else begin
      chk({7'h00, held}, 8'h01);
      chk_in(n, len - 2, len + 2);
      tick(2);
      chk({6'h00, ready_out, irq_grant_out}, 8'h03);
      @(posedge clk);
      maskable_irq_req_in <= 1'b0;
    end
    tick(3);
  endtask
  task automatic t_id(input logic good);
    rst(1'b1);
    for (int i = 0; i < 7; i++) begin
      @(posedge clk);
      id_byte_valid_in <= 1'b1;
      id_byte_in <= good ? id_stored_in[8*i +: 8] : ~id_stored_in[8*i +: 8];
    end
    @(posedge clk);
    id_byte_valid_in <= 1'b0;
    tick(3);
    chk({7'h00, serial_access_out}, {7'h00, good});
    rd_chk(8'h0C, 8'h05, {5'h00, good, 2'b01});
  endtask
  task automatic t_link;
    @(posedge clk);
    rxd_in <= 1'b0;
    serial_tx_bit_in <= 1'b0;
    serial_tx_en_in <= 1'b1;
    tick(3);
    chk({5'h00, txd_out, serial_rx_bit_out, mode_pin_oe_out}, 8'h00);
    @(posedge clk);
    variant3_sel_in <= 1'b1;
    hold <= 1'b0;
    rxd_in <= 1'b1;
    tick(3);
    chk({6'h00, mode_pin_oe_out, mode_pin_out}, 8'h02);
    @(posedge clk);
    serial_tx_en_in <= 1'b0;
    pg_en <= 1'b1;
    pg_bit <= 1'b0;
    tick(3);
    chk({6'h00, mode_pin_oe_out, serial_rx_bit_out}, 8'h00);
    @(posedge clk);
    pg_en <= 1'b0;
    tick(3);
    chk({7'h00, serial_rx_bit_out}, 8'h01);
  endtask
  task automatic t_exit;
    rst(1'b0);
    rd_chk(8'h0C, 8'h01, 8'h00);
    @(posedge clk);
    parallel_mode_in <= 1'b1;
    rom_code_protect_in <= 1'b1;
    tick(3);
    chk({5'h00, serial_access_out, parallel_rd_out, parallel_wr_out}, 8'h00);
    @(posedge clk);
    rom_code_protect_in <= 1'b0;
    tick(3);
    chk({6'h00, parallel_rd_out, parallel_wr_out}, 8'h03);
  endtask
  initial begin
    rst(1'b1);
    t_reset_vals;
    t_guard;
    t_abort;
    suspend_run(8'h02, 1'b1);
    suspend_run(8'h01, 1'b1);
    suspend_run(8'h02, 1'b0);
    suspend_run(8'h01, 1'b0);
    t_id(1'b0);
    t_id(1'b1);
    t_link;
    t_exit;
    results;
  end
  initial begin
    #200000;
    failures++;
    results;
  end
endmodule
`default_nettype wire
